// ### bench/lbsp_properties.sv
// Concurrent checks on the pins that join the host and device ends.
module lbsp_properties (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [22:2] addr,
    input wire logic        upperSegmentSelect,
    input wire logic        memIo,
    input wire logic        writeRead,
    input wire logic        addrStrobe_n,
    input wire logic        readyReturn_n,
    input wire logic        busReset,
    input wire logic        local_n,
    input wire logic        ready_n,
    input wire logic        devDataOe
);
    timeunit 1ns;
    timeprecision 1ns;
    // A strobe counts only while the device is free and out of reset.
    logic strobe;
    logic memHit; // Strobe that lands in the memory window.
    logic ioHit;  // Strobe that lands in the register window.
    assign strobe = !addrStrobe_n && !busReset && local_n;
    assign memHit = strobe && memIo && upperSegmentSelect && addr < 21'h40;
    assign ioHit  = strobe && !memIo && addr[15:4] == 12'h040;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    property p_memClaim;
        memHit |=> !local_n;
    endproperty
    a_memClaim: assert property (p_memClaim)
        else $error("no memory claim");
    property p_ioClaim;
        ioHit |=> !local_n;
    endproperty
    a_ioClaim: assert property (p_ioClaim)
        else $error("no io claim");
    // Misses must leave the shared claim line alone.
    property p_missFree;
        strobe && !memHit && !ioHit |=> local_n;
    endproperty
    a_missFree: assert property (p_missFree)
        else $error("miss claimed");
    // Three claimed cycles without ready come before ready.
    property p_readyTime;
        memHit || ioHit |=> (!local_n && ready_n)[*3] ##1 !ready_n;
    endproperty
    a_readyTime: assert property (p_readyTime)
        else $error("ready late");
    property p_readyPulse;
        !ready_n |=> ready_n;
    endproperty
    a_readyPulse: assert property (p_readyPulse)
        else $error("ready long");
    // Read data may not drop before the host returns ready.
    property p_readHold;
        devDataOe && readyReturn_n |=> devDataOe && !local_n;
    endproperty
    a_readHold: assert property (p_readHold)
        else $error("data dropped");
    property p_release;
        !readyReturn_n && !local_n |=> local_n && !devDataOe;
    endproperty
    a_release: assert property (p_release)
        else $error("not released");
    property p_resetIdle;
        busReset |=> local_n && ready_n && !devDataOe;
    endproperty
    a_resetIdle: assert property (p_resetIdle)
        else $error("busy in reset");
    cover property (memHit && !writeRead);
    cover property (ioHit && writeRead);
    cover property (devDataOe && readyReturn_n [*2]);
endmodule : lbsp_properties

// ### bench/local_bus_host_slave_port_tb.sv
// Self-checking bench joining the host and device ends of the port.
`include "lbsp_map.svh"
module local_bus_host_slave_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, reset_n, portReset, reqValid, reqWrite, rc;
    logic        reqMemory, holdReturn, irqEvent, reqReady, respDone;
    logic        respClaimed, irqSeen, irqPending, cycleServed;
    logic [31:2] reqAddr;
    logic [3:0]  reqByteEnable_n;
    logic [31:0] reqData, respData, rd;
    int          numErrors = 0; // Mismatches so far.
    int          checked = 0;   // Comparisons so far.
    lbsp_if busIf ();
    lbsp_host lbsp_host_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .bus(busIf), .portReset(portReset), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqMemory(reqMemory), .reqAddr(reqAddr),
        .reqByteEnable_n(reqByteEnable_n), .reqData(reqData),
        .holdReturn(holdReturn), .reqReady(reqReady), .respDone(respDone),
        .respClaimed(respClaimed), .respData(respData), .irqSeen(irqSeen));
    lbsp_device lbsp_device_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .bus(busIf), .irqEvent(irqEvent), .irqPending(irqPending),
        .cycleServed(cycleServed));
    lbsp_properties lbsp_properties_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .addr(busIf.addr), .upperSegmentSelect(busIf.upperSegmentSelect),
        .memIo(busIf.memIo), .writeRead(busIf.writeRead),
        .addrStrobe_n(busIf.addrStrobe_n), .busReset(busIf.busReset),
        .readyReturn_n(busIf.readyReturn_n), .local_n(busIf.local_n),
        .ready_n(busIf.ready_n), .devDataOe(busIf.devDataOe));
    // Free-running system clock.
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Counts a comparison and reports a failure at once.
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            numErrors++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask : chk
    // Word addresses inside the segment and inside the register window.
    function automatic logic [31:2] memA(input logic [20:0] w);
        return {`LBSP_SEGMENT, w};
    endfunction : memA
    function automatic logic [31:2] ioA(input logic [1:0] r);
        return {16'h00ff, `LBSP_IO_BASE, r};
    endfunction : ioA
    // One bus cycle; with hold the return stalls so the read must persist.
    task automatic xfer(input logic wr, mem, input logic [31:2] a,
            input logic [3:0] be, input logic [31:0] d, input logic hold);
        int n;
        for (n = 0; n < 40 && reqReady !== 1'b1; n++) @(negedge clk_sys);
        {reqValid, reqWrite, reqMemory, holdReturn} = {1'h1, wr, mem, hold};
        {reqAddr, reqByteEnable_n, reqData} = {a, be, d};
        @(negedge clk_sys);
        reqValid = 1'h0;
        if (hold) begin
            repeat (12) @(negedge clk_sys);
            chk(busIf.devDataOe & (busIf.dataBus === d), "held");
            holdReturn = 1'h0;
        end
        for (n = 0; n < 40 && respDone !== 1'b1; n++) @(negedge clk_sys);
        chk(respDone === 1'b1, "no response");
        {rc, rd} = {respClaimed, respData};
        @(negedge clk_sys);
        chk(cycleServed === rc, "served pulse");
    endtask : xfer
    // Byte lanes, the window edge, the segment decode and a stalled read.
    task automatic t_memory;
        xfer(1'h1, 1'h1, memA(21'h0), 4'h0, 32'h1122_3344, 1'h0);
        chk(rc === 1'b1, "write unclaimed");
        xfer(1'h1, 1'h1, memA(21'h0), 4'ha, 32'haabb_ccdd, 1'h0);
        xfer(1'h0, 1'h1, memA(21'h0), 4'h0, 32'h0, 1'h0);
        chk(rd === 32'h11bb_33dd, "lane merge");
        xfer(1'h1, 1'h1, memA(21'h3f), 4'h0, 32'h6363_6363, 1'h0);
        xfer(1'h0, 1'h1, memA(21'h40), 4'h0, 32'h0, 1'h0);
        chk(rc === 1'b0, "claimed past window");
        xfer(1'h0, 1'h1, {9'h002, 21'h0}, 4'h0, 32'h0, 1'h0);
        chk(rc === 1'b0, "claimed other segment");
        xfer(1'h0, 1'h1, memA(21'h3f), 4'h0, 32'h6363_6363, 1'h1);
        chk(rd === 32'h6363_6363, "stalled read");
        $display("t_memory done");
    endtask : t_memory
    // Register window decode ignores address bits above 15.
    task automatic t_io;
        xfer(1'h1, 1'h0, ioA(2'h1), 4'h0, 32'h5a5a_0001, 1'h0);
        xfer(1'h0, 1'h0, ioA(2'h1), 4'h0, 32'h0, 1'h0);
        chk(rc & (rd === 32'h5a5a_0001), "io readback");
        xfer(1'h0, 1'h0, {16'h00ff, 12'h041, 2'h1}, 4'h0, 32'h0, 1'h0);
        chk(rc === 1'b0, "io miss claimed");
        xfer(1'h0, 1'h0, memA(21'h0), 4'h0, 32'h0, 1'h0);
        chk(rc === 1'b0, "memory claimed as io");
        $display("t_io done");
    endtask : t_io
    // Raise, read and clear the interrupt, then a port reset clears it.
    task automatic t_irq;
        irqEvent = 1'h1;
        @(negedge clk_sys);
        irqEvent = 1'h0;
        repeat (3) @(negedge clk_sys);
        chk(!busIf.interruptRequest_n & irqSeen, "irq pin");
        xfer(1'h0, 1'h0, ioA(2'h0), 4'h0, 32'h0, 1'h0);
        chk(rd[0] === 1'b1, "irq status");
        xfer(1'h1, 1'h0, ioA(2'h0), 4'he, 32'h1, 1'h0);
        repeat (3) @(negedge clk_sys);
        chk(busIf.interruptRequest_n & !irqSeen, "irq clear");
        irqEvent = 1'h1;
        @(negedge clk_sys);
        {irqEvent, portReset} = 2'h1;
        repeat (4) @(negedge clk_sys);
        chk(irqPending === 1'b0, "pending kept");
        xfer(1'h0, 1'h1, memA(21'h0), 4'h0, 32'h0, 1'h0);
        chk(rc === 1'b0, "claimed in reset");
        portReset = 1'h0;
        repeat (3) @(negedge clk_sys);
        xfer(1'h0, 1'h1, memA(21'h0), 4'h0, 32'h0, 1'h0);
        chk(rc === 1'b1, "no claim after reset");
        $display("t_irq done");
    endtask : t_irq
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("checks %0d errors %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    // Main sequence: reset for five cycles, then each test in turn.
    initial begin
        {reset_n, portReset, reqValid, reqWrite, reqMemory} = 5'h0;
        {holdReturn, irqEvent, reqByteEnable_n} = 6'h0f;
        {reqAddr, reqData} = 62'h0;
        repeat (5) @(negedge clk_sys);
        reset_n = 1'h1;
        repeat (3) @(negedge clk_sys);
        t_memory();
        t_io();
        t_irq();
        summarize();
    end
    // Watchdog: the tests need a few hundred cycles at most.
    initial begin
        repeat (3000) @(posedge clk_sys);
        numErrors++;
        $display("ERROR %0t: watchdog expired", $time);
        summarize();
    end
endmodule : local_bus_host_slave_port_tb

// ### rtl/lbsp_device.sv
// Device end: claims, serves and terminates local bus cycles.
//
// Notes on behaviour
// - 32-bit data bus, device drives reads only.
// - Address lines 22:2 are inputs, decode memory.
// - I/O registers decode address bits 15:2 only.
// - Outside logic decodes bits 31:23 to segment select.
// - Host drives four active-low byte lane enables.
// - Memory/IO status low means I/O cycle.
// - Write/read status high write, low read.
// - Host strobe marks address and status valid.
// - All port activity timed from bus clock.
// - Unreturned ready extends cycle, read data held.
// - Claim asserted for addresses the device owns.
// - Open-collector ready ends each served cycle.
// - Held in reset while reset input high.
// - Interrupt output low while condition pending.
`include "lbsp_map.svh"
module lbsp_device #(
    parameter int MEM_WORDS = 64,   // Words of device memory.
    parameter int IO_WORDS  = 4     // Words of I/O register space.
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    lbsp_if.device    bus,
    input  wire logic irqEvent,
    output logic      irqPending,
    output logic      cycleServed
);
    import lbsp_pkg::*;

    localparam int MW = $clog2(MEM_WORDS);  // Memory index width.
    localparam int IW = $clog2(IO_WORDS);   // I/O index width.

    // Merges write data into a word lane by lane under active-low enables.
    function automatic logic [31:0] mergeLanes(input logic [31:0] oldWord,
                                               input logic [31:0] newWord,
                                               input logic [3:0]  enable_n);
        logic [31:0] result;
        result = oldWord;
        for (int lane = 0; lane < 4; lane++) begin
            if (!enable_n[lane]) begin
                result[lane*8 +: 8] = newWord[lane*8 +: 8];
            end
        end
        return result;
    endfunction : mergeLanes

    lbsp_dev_t   state_q;                 // Cycle sequencer state.
    logic [3:0]  waitCount_q;             // Wait cycles left before ready.
    logic        isMem_q;                 // Claimed cycle targets memory.
    logic        isWrite_q;               // Claimed cycle is a write.
    logic [MW-1:0] memIndex_q;            // Latched memory word index.
    logic [IW-1:0] ioIndex_q;             // Latched I/O word index.
    logic [3:0]  lanes_n_q;               // Latched byte enables.
    logic [31:0] memory [MEM_WORDS];      // Device memory.
    logic [31:0] ioRegs [IO_WORDS];       // General I/O registers.
    logic [31:0] readWord;                // Word selected for a read.
    logic        memHit;                  // Strobed cycle hits memory.
    logic        ioHit;                   // Strobed cycle hits I/O space.
    logic        held;                    // Port-level reset is active.
    logic        irqClear;                // Host write clears the flag.

    // The reset pin comes from logic on this clock, so it needs no
    // synchroniser; it idles the sequencer, flag and pin drivers, while memory and registers keep their contents.
    assign held = bus.busReset;

    // Memory claim needs the external segment select and a word that
    // exists; bits above the array must be zero so nothing aliases.
    assign memHit = !bus.addrStrobe_n && bus.memIo
                    && bus.upperSegmentSelect
                    && (bus.addr[`LBSP_ADDR_TOP:2]
                        < 21'(MEM_WORDS));
    // I/O decode looks at bits 15:2 only, so the window repeats every
    // 64 KiB of I/O space, as a narrow decoder on the bus would.
    assign ioHit = !bus.addrStrobe_n && !bus.memIo
                   && (bus.addr[`LBSP_IO_TOP:4] == `LBSP_IO_BASE)
                   && (int'(bus.addr[3:2]) < IO_WORDS);

    // Read data comes from memory or the I/O space, where the interrupt
    // register shows the pending flag in its low bit.
    always_comb begin
        if (isMem_q) begin
            readWord = memory[memIndex_q];
        end else if (ioIndex_q == IW'(`LBSP_IO_IRQ)) begin
            readWord = 32'h0000_0000;
            readWord[`LBSP_IRQ_BIT] = irqPending;
        end else begin
            readWord = ioRegs[ioIndex_q];
        end
    end

    // Cycle sequencer: claim, wait, ready, then hold until returned.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= DevIdle;
            waitCount_q <= 4'h0;
            isMem_q     <= 1'b0;
            isWrite_q   <= 1'b0;
            memIndex_q  <= '0;
            ioIndex_q   <= '0;
            lanes_n_q   <= 4'hf;
        end else if (held) begin
            state_q     <= DevIdle;
            waitCount_q <= 4'h0;
            isMem_q     <= 1'b0;
            isWrite_q   <= 1'b0;
            memIndex_q  <= '0;
            ioIndex_q   <= '0;
            lanes_n_q   <= 4'hf;
        end else begin
            case (state_q)
                DevIdle: begin
                    // Cycles outside our space are left to other slaves.
                    if (memHit || ioHit) begin
                        state_q     <= DevWait;
                        waitCount_q <= `LBSP_WAIT_CYCLES;
                        isMem_q     <= memHit;
                        isWrite_q   <= bus.writeRead;
                        memIndex_q  <= bus.addr[MW+1:2];
                        ioIndex_q   <= bus.addr[IW+1:2];
                        lanes_n_q   <= bus.byteEnable_n;
                    end
                end
                DevWait: begin
                    // Gives the host time to settle write data.
                    if (waitCount_q == 4'h0) begin
                        state_q <= DevReady;
                    end else begin
                        waitCount_q <= waitCount_q - 4'h1;
                    end
                end
                DevReady: begin
                    state_q <= DevHold;
                end
                DevHold: begin
                    // The cycle stays open until the host returns ready.
                    if (!bus.readyReturn_n) begin
                        state_q <= DevIdle;
                    end
                end
                default: begin
                    state_q <= DevIdle;
                end
            endcase
        end
    end

    // Writes land in the cycle before ready, when host data is stable.
    always_ff @(posedge clk_sys) begin
        if (!held && state_q == DevWait && waitCount_q == 4'h0
            && isWrite_q) begin
            if (isMem_q) begin
                memory[memIndex_q] <= mergeLanes(memory[memIndex_q],
                                                 bus.dataBus,
                                                 lanes_n_q);
            end else begin
                ioRegs[ioIndex_q] <= mergeLanes(ioRegs[ioIndex_q],
                                                bus.dataBus, lanes_n_q);
            end
        end
    end

    // A write of one to the flag bit of the interrupt register clears it.
    assign irqClear = !held && state_q == DevWait && waitCount_q == 4'h0
                      && isWrite_q && !isMem_q
                      && ioIndex_q == IW'(`LBSP_IO_IRQ)
                      && !lanes_n_q[0] && bus.dataBus[`LBSP_IRQ_BIT];

    // Pending flag: a new event in the clearing cycle wins over the clear.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqPending <= 1'b0;
        end else if (held) begin
            irqPending <= 1'b0;
        end else if (irqEvent) begin
            irqPending <= 1'b1;
        end else if (irqClear) begin
            irqPending <= 1'b0;
        end
    end

    // Interrupt pin follows the flag one clock later from its own flop.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus.interruptOut_n <= 1'b1;
            bus.interruptOe    <= 1'b0;
        end else begin
            bus.interruptOut_n <= !irqPending;
            bus.interruptOe    <= irqPending;
        end
    end

    // Claim pin is driven low from the edge after the strobe until the
    // host returns ready; otherwise it floats high.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus.localOut_n <= 1'b1;
            bus.localOe    <= 1'b0;
        end else if (held) begin
            bus.localOut_n <= 1'b1;
            bus.localOe    <= 1'b0;
        end else if (state_q == DevIdle && (memHit || ioHit)) begin
            bus.localOut_n <= 1'b0;
            bus.localOe    <= 1'b1;
        end else if (state_q == DevHold && !bus.readyReturn_n) begin
            bus.localOut_n <= 1'b1;
            bus.localOe    <= 1'b0;
        end
    end

    // Ready is open collector: pulled low for one clock, else released.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus.readyOut_n <= 1'b1;
            bus.readyOe    <= 1'b0;
        end else begin
            bus.readyOut_n <= 1'b0;
            bus.readyOe    <= !held && state_q == DevWait
                              && waitCount_q == 4'h0;
        end
    end

    // Read data is driven with ready and kept until the host returns it,
    // so a slow host still samples a stable word.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus.devDataOut <= 32'h0000_0000;
            bus.devDataOe  <= 1'b0;
        end else if (held) begin
            bus.devDataOut <= 32'h0000_0000;
            bus.devDataOe  <= 1'b0;
        end else if (state_q == DevWait && waitCount_q == 4'h0
                     && !isWrite_q) begin
            bus.devDataOut <= readWord;
            bus.devDataOe  <= 1'b1;
        end else if (state_q == DevHold && !bus.readyReturn_n) begin
            bus.devDataOe  <= 1'b0;
        end
    end

    // One-cycle pulse per served cycle, for the user side.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cycleServed <= 1'b0;
        end else begin
            cycleServed <= !held && state_q == DevHold
                           && !bus.readyReturn_n;
        end
    end
endmodule : lbsp_device

// ### rtl/lbsp_host.sv
// Host end: runs local bus cycles and the upper address decoder.
`include "lbsp_map.svh"
module lbsp_host (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    lbsp_if.host             bus,
    input  wire logic        portReset,
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic        reqMemory,
    input  wire logic [31:2] reqAddr,
    input  wire logic [3:0]  reqByteEnable_n,
    input  wire logic [31:0] reqData,
    input  wire logic        holdReturn,
    output logic             reqReady,
    output logic             respDone,
    output logic             respClaimed,
    output logic [31:0]      respData,
    output logic             irqSeen
);
    import lbsp_pkg::*;

    lbsp_host_t state_q;      // Host cycle state.
    logic [3:0] claimWait_q;  // Cycles left for a claim to appear.
    logic       claimed_q;    // The device has claimed this cycle.

    // Cycle engine: strobe, wait for claim and ready, then return ready.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q                <= HostIdle;
            claimWait_q            <= 4'h0;
            claimed_q              <= 1'b0;
            reqReady               <= 1'b0;
            respDone               <= 1'b0;
            respClaimed            <= 1'b0;
            respData               <= 32'h0000_0000;
            bus.addrStrobe_n       <= 1'b1;
            bus.readyReturn_n      <= 1'b1;
            bus.addr               <= '0;
            bus.upperSegmentSelect <= 1'b0;
            bus.byteEnable_n       <= 4'hf;
            bus.memIo              <= 1'b0;
            bus.writeRead          <= 1'b0;
            bus.hostDataOut        <= 32'h0000_0000;
            bus.hostDataOe         <= 1'b0;
        end else begin
            respDone          <= 1'b0;
            reqReady          <= 1'b0;
            bus.addrStrobe_n  <= 1'b1;
            bus.readyReturn_n <= 1'b1;
            case (state_q)
                HostIdle: begin
                    reqReady <= 1'b1;
                    if (reqValid && reqReady) begin
                        // Strobe and status go out together for one clock.
                        state_q                <= HostAddr;
                        reqReady               <= 1'b0;
                        claimed_q              <= 1'b0;
                        claimWait_q            <= `LBSP_CLAIM_LIMIT;
                        bus.addrStrobe_n       <= 1'b0;
                        bus.addr               <= reqAddr[22:2];
                        bus.upperSegmentSelect <= reqMemory &&
                            (reqAddr[31:23] == `LBSP_SEGMENT);
                        bus.byteEnable_n       <= reqByteEnable_n;
                        bus.memIo              <= reqMemory;
                        bus.writeRead          <= reqWrite;
                        bus.hostDataOut        <= reqData;
                        bus.hostDataOe         <= reqWrite;
                    end
                end
                HostAddr: begin
                    state_q <= HostWait;
                end
                HostWait: begin
                    // Unclaimed cycles time out instead of hanging the bus.
                    if (!bus.local_n) begin
                        claimed_q <= 1'b1;
                    end
                    if (!bus.ready_n) begin
                        respData  <= bus.dataBus;
                        state_q   <= HostDone;
                    end else if (!claimed_q && bus.local_n) begin
                        if (claimWait_q == 4'h0) begin
                            state_q        <= HostIdle;
                            respDone       <= 1'b1;
                            respClaimed    <= 1'b0;
                            bus.hostDataOe <= 1'b0;
                        end else begin
                            claimWait_q <= claimWait_q - 4'h1;
                        end
                    end
                end
                HostDone: begin
                    // The user may stall the return to stretch the cycle.
                    if (!holdReturn) begin
                        bus.readyReturn_n <= 1'b0;
                        bus.hostDataOe    <= 1'b0;
                        respDone          <= 1'b1;
                        respClaimed       <= 1'b1;
                        state_q           <= HostIdle;
                    end
                end
                default: begin
                    state_q <= HostIdle;
                end
            endcase
        end
    end

    // Port reset pin and interrupt level, registered for clean pins.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus.busReset <= 1'b1;
            irqSeen      <= 1'b0;
        end else begin
            bus.busReset <= portReset;
            irqSeen      <= !bus.interruptRequest_n;
        end
    end
endmodule : lbsp_host

// ### rtl/lbsp_if.sv
// Pin bundle between the local bus host and the device port.
interface lbsp_if;
    logic [31:0] hostDataOut;        // Data the host drives on writes.
    logic        hostDataOe;         // Host drives the data bus.
    logic [31:0] devDataOut;         // Data the device drives on reads.
    logic        devDataOe;          // Device drives the data bus.
    logic [31:0] dataBus;            // Resolved level of the data bus.
    logic [22:2] addr;               // Host address lines, device inputs.
    logic        upperSegmentSelect; // Decoded address bits 31:23.
    logic [3:0]  byteEnable_n;       // Active-low lane enables.
    logic        memIo;              // High memory cycle, low I/O cycle.
    logic        writeRead;          // High write, low read.
    logic        addrStrobe_n;       // Address and status valid.
    logic        readyReturn_n;      // Ends the cycle at the device.
    logic        busReset;           // Active-high device reset.
    logic        localOut_n;         // Claim output level.
    logic        localOe;            // Claim output enable.
    logic        local_n;            // Resolved claim line, pulled up.
    logic        readyOut_n;         // Ready output level.
    logic        readyOe;            // Ready open-collector enable.
    logic        ready_n;            // Resolved ready line, pulled up.
    logic        interruptOut_n;     // Interrupt output level.
    logic        interruptOe;        // Interrupt output enable.
    logic        interruptRequest_n; // Resolved interrupt line.

    // Pull-ups resolve released control lines high, a released data bus reads zero; device wins the data bus.
    assign dataBus = devDataOe ? devDataOut :
                     (hostDataOe ? hostDataOut : 32'h0000_0000);
    assign local_n = localOe ? localOut_n : 1'b1;
    assign ready_n = readyOe ? readyOut_n : 1'b1;
    assign interruptRequest_n = interruptOe ? interruptOut_n : 1'b1;

    modport device (
        input  dataBus, addr, upperSegmentSelect, byteEnable_n, memIo,
               writeRead, addrStrobe_n, readyReturn_n, busReset,
        output devDataOut, devDataOe, localOut_n, localOe, readyOut_n,
               readyOe, interruptOut_n, interruptOe
    );
    modport host (
        input  dataBus, local_n, ready_n, interruptRequest_n,
        output hostDataOut, hostDataOe, addr, upperSegmentSelect,
               byteEnable_n, memIo, writeRead, addrStrobe_n,
               readyReturn_n, busReset
    );
endinterface : lbsp_if

// ### rtl/lbsp_map.svh
// Address map, field positions and timing counts of the local bus port.
`ifndef LBSP_MAP_SVH
`define LBSP_MAP_SVH
// Top host address bit that the device sees on its address pins.
`define LBSP_ADDR_TOP      22
// Top host address bit used to decode the I/O register window.
`define LBSP_IO_TOP        15
// Value of address bits 15:4 that selects the I/O register window.
`define LBSP_IO_BASE       12'h040
// I/O register index of the interrupt status and clear register.
`define LBSP_IO_IRQ        2'h0
// Bit of the interrupt register that holds the pending flag.
`define LBSP_IRQ_BIT       0
// Host address bits 31:23 that the external decoder accepts.
`define LBSP_SEGMENT       9'h001
// Device wait count; claim leads ready by this many cycles plus one.
`define LBSP_WAIT_CYCLES   4'h2
// Host cycles to wait for a claim before ending an unclaimed cycle.
`define LBSP_CLAIM_LIMIT   4'h3
`endif

// ### rtl/lbsp_pkg.sv
// Types shared by both ends of the local bus port.
package lbsp_pkg;
    // States of the device end of a bus cycle.
    typedef enum logic [1:0] {DevIdle, DevWait, DevReady, DevHold} lbsp_dev_t;
    // States of the host end of a bus cycle.
    typedef enum logic [1:0] {HostIdle, HostAddr, HostWait, HostDone}
        lbsp_host_t;
endpackage : lbsp_pkg
